// ==== hw/card_host_bus.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "card_bus_defines.svh"

module card_host_bus (
  input wire logic core_clk_i, // 50 MHz core clock
  input wire logic arst_n_i, // Async reset, active low
  input wire logic link_clk_i, // Received bus clock, sampled
  input wire logic host_reset_i, // Card reset from host, active high
  input wire logic [25:0] outbound_pixel_bus_i, // Host data
  input wire logic outbound_pixel_valid_i, // Host pixel enable
  output logic [25:0] inbound_pixel_bus_o, // Card data to host
  output logic inbound_pixel_valid_o, // Card pixel enable
  input wire logic cfg_serial_clk_i, // Serial port clock
  input wire logic cfg_serial_sync_i, // Serial port sync
  input wire logic cfg_serial_data_i, // Serial write data
  output logic cfg_serial_return_data_o, // Serial return data
  input wire logic twowire_clk_i, // Host two-wire clock
  input wire logic twowire_data_i, // Host two-wire data
  output logic twowire_data_return_o, // Two-wire return data
  output logic twowire_clk_o, // To video chips, clock
  output logic twowire_data_o, // To video chips, data out
  output logic twowire_data_oe_n_o, // Low while driving data
  input wire logic twowire_chip_data_i, // Data from video chips
  input wire logic [29:0] dec_port_i, // Decoder pixel port
  input wire logic dec_valid_i, // Decoder sample strobe
  output logic [25:0] outbound_pixel_o, // Received host pixel
  output logic outbound_pixel_valid_o, // Received pixel strobe
  output logic [15:0] cfg_ctrl_o // Control register
);
  // ==========================================
  // Reset and synchronisers
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] lclk_q, sclk_q;
  logic [1:0] sync_q, sdat_q, hrst_q, tclk_q, tdat_q, tchip_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_q <= 2'b00;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lclk_q <= '0;
      sclk_q <= 3'b111; // Serial clock idles high: no false rise after reset
      sync_q <= '0;
      sdat_q <= '0;
      hrst_q <= 2'b11;
      tclk_q <= 2'b11;
      tdat_q <= 2'b11;
      tchip_q <= 2'b11;
    end
    else
    begin
      lclk_q <= {lclk_q[1:0], link_clk_i};
      sclk_q <= {sclk_q[1:0], cfg_serial_clk_i};
      sync_q <= {sync_q[0], cfg_serial_sync_i};
      sdat_q <= {sdat_q[0], cfg_serial_data_i};
      hrst_q <= {hrst_q[0], host_reset_i};
      tclk_q <= {tclk_q[0], twowire_clk_i};
      tdat_q <= {tdat_q[0], twowire_data_i};
      tchip_q <= {tchip_q[0], twowire_chip_data_i};
    end
  end

  logic card_rst, lrise, srise;
  assign card_rst = hrst_q[1];
  assign lrise = lclk_q[1] && !lclk_q[2];
  assign srise = sclk_q[1] && !sclk_q[2];

  // ==========================================
  // Two-wire pass-through
  // Held as flops so the chip side sees clean levels
  logic tw_clk_q, tw_dat_q, tw_ret_q;
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tw_clk_q <= 1'b1;
      tw_dat_q <= 1'b1;
      tw_ret_q <= 1'b1;
    end
    else
    begin
      tw_clk_q <= tclk_q[1];
      tw_dat_q <= tdat_q[1];
      tw_ret_q <= tchip_q[1] & tdat_q[1];
    end
  end
  assign twowire_clk_o = tw_clk_q;
  assign twowire_data_o = 1'b0;
  assign twowire_data_oe_n_o = tw_dat_q; // Open drain: drive low only
  assign twowire_data_return_o = tw_ret_q;

  // ==========================================
  // Outbound capture on received clock edges
  logic [25:0] ob_q, ob_d;
  logic obv_q, obv_d;
  always_comb
  begin
    ob_d = ob_q;
    obv_d = 1'b0;
    if (lrise)
    begin
      ob_d = outbound_pixel_bus_i;
      obv_d = outbound_pixel_valid_i;
    end
  end

  // ==========================================
  // Inbound path: decoder slice through FIFO
  logic [25:0] dec_word, fifo_data;
  logic fifo_valid, fifo_pop, fifo_wr_ready;
  logic [25:0] ib_q, ib_d;
  logic ibv_q, ibv_d;
  assign dec_word = {{(`PIX_W-`DEC_SLICE_W){1'b0}},
                     dec_port_i[`DEC_SLICE_LSB+`DEC_SLICE_W-1:`DEC_SLICE_LSB]};
  assign fifo_pop = lrise && fifo_valid && !card_rst;

  pixel_fifo #(.WIDTH(`PIX_W), .DEPTH(`FIFO_DEPTH), .PTR_W(`FIFO_PTR_W)) u_fifo (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .wr_data_i(dec_word),
    .wr_valid_i(dec_valid_i && !card_rst && cfg_ctrl_o[0]),
    .wr_ready_o(fifo_wr_ready),
    .rd_data_o(fifo_data),
    .rd_valid_o(fifo_valid),
    .rd_ready_i(fifo_pop)
  );

  always_comb
  begin
    ib_d = ib_q;
    ibv_d = ibv_q;
    if (lrise)
    begin
      ib_d = fifo_pop ? fifo_data : ib_q;
      ibv_d = fifo_pop;
    end
  end

  // ==========================================
  // Serial configuration port
  card_bus_pkg::sport_state_e st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] sh_q, sh_d;
  logic [15:0] regs_q [`CFG_NREGS];
  logic [15:0] regs_d [`CFG_NREGS];
  logic ret_q, ret_d;
  logic [15:0] ovf_q, ovf_d;
  logic [`CFG_IDX_W-1:0] widx;
  assign widx = sh_q[`CFG_ADDR_MSB-14:`CFG_DATA_MSB+1];

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ret_d = ret_q;
    ovf_d = ovf_q + 16'(dec_valid_i && !fifo_wr_ready);
    for (int i = 0; i < `CFG_NREGS; i++)
      regs_d[i] = regs_q[i];
    regs_d[`CFG_STAT_IDX] = {14'h0000, fifo_valid, card_rst};
    regs_d[3] = ovf_q;
    unique case (st_q)
      card_bus_pkg::SP_IDLE:
        if (srise && sync_q[1])
        begin
          st_d = card_bus_pkg::SP_SHIFT;
          cnt_d = 6'h00;
        end
      card_bus_pkg::SP_SHIFT:
        if (srise)
        begin
          sh_d = {sh_q[30:0], sdat_q[1]};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'(`CFG_FRAME_W - 1))
            st_d = card_bus_pkg::SP_RET;
        end
      card_bus_pkg::SP_RET:
      begin
        // top 16 bits address, low 16 bits data
        if (sh_q[`CFG_ADDR_MSB:`CFG_ADDR_MSB-13] == 14'h0000 &&
            widx != `CFG_STAT_IDX && widx != 2'h3)
          regs_d[widx] = sh_q[`CFG_DATA_MSB:0];
        ret_d = 1'b0;
        sh_d = {regs_q[widx], 16'h0000};
        st_d = card_bus_pkg::SP_IDLE;
      end
    endcase
    // Return line carries the addressed register msb first on later clocks
    if (st_q == card_bus_pkg::SP_IDLE && srise && !sync_q[1])
    begin
      ret_d = sh_q[31];
      sh_d = {sh_q[30:0], 1'b0};
    end
    if (card_rst)
    begin
      st_d = card_bus_pkg::SP_IDLE;
      regs_d[`CFG_CTRL_IDX] = `CFG_CTRL_RST;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ob_q <= '0;
      obv_q <= 1'b0;
      ib_q <= '0;
      ibv_q <= 1'b0;
      st_q <= card_bus_pkg::SP_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      ret_q <= 1'b0;
      ovf_q <= '0;
      for (int i = 0; i < `CFG_NREGS; i++)
        regs_q[i] <= (i == 0) ? `CFG_CTRL_RST : 16'h0000;
    end
    else
    begin
      ob_q <= ob_d;
      obv_q <= obv_d;
      ib_q <= ib_d;
      ibv_q <= ibv_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ret_q <= ret_d;
      ovf_q <= ovf_d;
      for (int i = 0; i < `CFG_NREGS; i++)
        regs_q[i] <= regs_d[i];
    end
  end

  assign outbound_pixel_o = ob_q;
  assign outbound_pixel_valid_o = obv_q;
  assign inbound_pixel_bus_o = ib_q;
  assign inbound_pixel_valid_o = ibv_q;
  assign cfg_serial_return_data_o = ret_q;
  assign cfg_ctrl_o = regs_q[`CFG_CTRL_IDX];
endmodule : card_host_bus
`default_nettype wire

// ==== hw/card_bus_defines.svh ====
`ifndef CARD_BUS_DEFINES_SVH
`define CARD_BUS_DEFINES_SVH

// ==========================================
// Bus widths and FIFO depth
`define PIX_W 26
`define CFG_ADDR_W 16
`define CFG_DATA_W 16
`define CFG_FRAME_W 32
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4

// ==========================================
// Decoder slice and field positions
`define DEC_SLICE_LSB 12
`define DEC_SLICE_W 8
`define DEC_PORT_W 30
`define CFG_ADDR_MSB 31
`define CFG_DATA_MSB 15

// ==========================================
// Register file of the card, reached over the serial port
`define CFG_NREGS 4
`define CFG_IDX_W 2
`define CFG_CTRL_IDX 2'h0
`define CFG_STAT_IDX 2'h1
`define CFG_SCRATCH_IDX 2'h2
`define CFG_CTRL_RST 16'h0001

`endif

// ==== hw/card_bus_pkg.sv ====
package card_bus_pkg;
  typedef enum logic [2:0]
  {
    SP_IDLE = 3'b001,
    SP_SHIFT = 3'b010,
    SP_RET = 3'b100
  } sport_state_e;
  typedef logic [25:0] pixel_t;
endpackage : card_bus_pkg

// ==== hw/pixel_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronised reset
  input wire logic [WIDTH-1:0] wr_data_i, // Write word
  input wire logic wr_valid_i, // Write request
  output logic wr_ready_o, // Not full
  output logic [WIDTH-1:0] rd_data_o, // Head word
  output logic rd_valid_o, // Not empty
  input wire logic rd_ready_i // Pop
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PTR_W:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  assign wr_ready_o = (wp_q[PTR_W] == rp_q[PTR_W]) || (wp_q[PTR_W-1:0] != rp_q[PTR_W-1:0]);
  assign rd_valid_o = (wp_q != rp_q);
  assign push = wr_valid_i && wr_ready_o;
  assign pop = rd_valid_o && rd_ready_i;
  assign rd_data_o = mem_q[rp_q[PTR_W-1:0]];

  always_comb
  begin
    wp_d = wp_q + (PTR_W+1)'(push);
    rp_d = rp_q + (PTR_W+1)'(pop);
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_comb
    begin
      mem_d[i] = (push && wp_q[PTR_W-1:0] == PTR_W'(i)) ? wr_data_i : mem_q[i];
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        mem_q[i] <= '0;
      else
        mem_q[i] <= mem_d[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
endmodule : pixel_fifo
`default_nettype wire

// ==== tb/card_bus_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module card_bus_monitor (
  input wire logic core_clk_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic host_reset_i, // Card reset
  input wire logic twowire_data_i, // Host data
  input wire logic twowire_chip_data_i, // Chip data
  input wire logic twowire_data_return_o, // Return
  input wire logic twowire_data_o, // Chip out
  input wire logic twowire_data_oe_n_o, // Chip enable
  input wire logic [25:0] inbound_pixel_bus_o, // Card data
  input wire logic inbound_pixel_valid_o, // Card enable
  input wire logic outbound_pixel_valid_o, // Pixel strobe
  input wire logic [15:0] cfg_ctrl_o // Control
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // =====
  // Inbound word handover and outbound strobe
  sequence s_word_up;
    $rose(inbound_pixel_valid_o);
  endsequence
  sequence s_word_held;
    $stable(inbound_pixel_bus_o) [*3];
  endsequence
  AST_IN_HELD: assert property (s_word_up |=> s_word_held)
    else $error("inbound word changed early");
  AST_IN_VALID: assert property (s_word_up |=> inbound_pixel_valid_o [*3])
    else $error("inbound enable too short");
  AST_IN_SLICE: assert property (inbound_pixel_valid_o |-> inbound_pixel_bus_o[25:8] == 18'h0)
    else $error("inbound word wider than slice");
  AST_OUT_PULSE: assert property (outbound_pixel_valid_o |=> !outbound_pixel_valid_o)
    else $error("pixel strobe too long");
  // =====
  // Two-wire lines and control reset, sync latency allowed for
  AST_TW_DATA_LOW: assert property (twowire_data_o == 1'b0)
    else $error("chip data not low");
  AST_TW_RET_HIGH: assert property ((twowire_data_i && twowire_chip_data_i) [*5] |-> twowire_data_return_o)
    else $error("return not high");
  AST_TW_RET_LOW: assert property ((!twowire_chip_data_i) [*5] |-> !twowire_data_return_o)
    else $error("return not low");
  AST_TW_OE: assert property ((!twowire_data_i) [*5] |-> !twowire_data_oe_n_o)
    else $error("chip data not driven");
  AST_CTRL_RST: assert property (host_reset_i [*5] |-> cfg_ctrl_o == 16'h0001)
    else $error("control not reset");
endmodule : card_bus_monitor
bind card_host_bus card_bus_monitor u_mon (.core_clk_i, .arst_n_i, .host_reset_i,
  .twowire_data_i, .twowire_chip_data_i, .twowire_data_return_o, .twowire_data_o,
  .twowire_data_oe_n_o, .inbound_pixel_bus_o, .inbound_pixel_valid_o,
  .outbound_pixel_valid_o, .cfg_ctrl_o);
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic core_clk_i, // Clock
  input wire logic sret_i, // Serial return
  output logic link_clk_o = 1'b0, // Bus clock
  output logic [25:0] pix_o = '0, // Outbound word
  output logic pix_valid_o = 1'b0, // Outbound enable
  output logic sclk_o = 1'b1, // Serial clock
  output logic ssync_o = 1'b0, // Serial sync
  output logic sdata_o = 1'b0 // Serial data
);
  logic run = 1'b0;
  int ph = 0;
  // =====
  // Stopping the clock stalls the card's drain
  always @(posedge core_clk_i)
  begin
    ph <= run ? (ph + 1) % 8 : 0;
    link_clk_o <= run && (ph < 4);
  end
  task automatic pixel(input logic [25:0] d);
    @(negedge link_clk_o);
    @(posedge core_clk_i);
    pix_o <= d;
    pix_valid_o <= 1'b1;
    @(negedge link_clk_o);
    @(posedge core_clk_i);
    pix_o <= ~d;
    pix_valid_o <= 1'b0;
  endtask : pixel
  task automatic frame(input logic [31:0] w, output logic [15:0] r);
    for (int n = 1; n <= 50; n++)
    begin
      @(posedge core_clk_i);
      sclk_o <= 1'b0;
      ssync_o <= (n == 1);
      sdata_o <= (n > 1 && n < 34) ? w[33 - n] : ~sdata_o;
      repeat (5) @(posedge core_clk_i);
      if (n > 34)
        r = {r[14:0], sret_i};
      sclk_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
    end
  endtask : frame
endmodule : host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h, expected %h", $time, (a), (b)); end end
module tb;
  logic core_clk_i = 0, arst_n_i = 0, host_reset_i = 0, twowire_clk_i = 0;
  logic twowire_data_i = 1, twowire_chip_data_i = 1, dec_valid_i = 0;
  logic [29:0] dec_port_i = '0;
  logic [15:0] r;
  logic [7:0] v;
  wire logic link_clk, pix_v, sclk, ssync, sdata, sret, in_v, out_v, tw_ret, tw_clk_o, tw_d, tw_oe_n;
  wire logic [25:0] pix, in_bus, out_pix;
  wire logic [15:0] ctrl;
  int bad_count = 0, checks_done = 0, cyc = 0;
  card_host_bus DUT (.core_clk_i, .arst_n_i, .link_clk_i(link_clk), .host_reset_i,
    .outbound_pixel_bus_i(pix), .outbound_pixel_valid_i(pix_v), .inbound_pixel_bus_o(in_bus),
    .inbound_pixel_valid_o(in_v), .cfg_serial_clk_i(sclk), .cfg_serial_sync_i(ssync),
    .cfg_serial_data_i(sdata), .cfg_serial_return_data_o(sret), .twowire_clk_i,
    .twowire_data_i, .twowire_data_return_o(tw_ret), .twowire_clk_o(tw_clk_o),
    .twowire_data_o(tw_d), .twowire_data_oe_n_o(tw_oe_n), .twowire_chip_data_i,
    .dec_port_i, .dec_valid_i, .outbound_pixel_o(out_pix), .outbound_pixel_valid_o(out_v),
    .cfg_ctrl_o(ctrl));
  host_model u_host (.core_clk_i, .sret_i(sret), .link_clk_o(link_clk), .pix_o(pix),
    .pix_valid_o(pix_v), .sclk_o(sclk), .ssync_o(ssync), .sdata_o(sdata));
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  // =====
  // Fill with drain stalled, then drain
  task automatic test_fill();
    for (int i = 0; i < 17; i++)
    begin
      @(posedge core_clk_i);
      dec_port_i <= {10'h2aa, 8'(8'h40 + i), 12'h555};
      dec_valid_i <= 1'b1;
    end
    @(posedge core_clk_i);
    dec_valid_i <= 1'b0;
    u_host.run <= 1'b1;
    `CHK(in_v, 1'b0)
    for (int i = 0; i < 17; i++)
    begin
      @(posedge link_clk);
      repeat (6) @(posedge core_clk_i);
      v = 8'(8'h40 + i);
      if (i < 16)
        `CHK(in_bus, {18'h0, v})
      else
        `CHK(in_v, 1'b0)
    end
    u_host.frame({16'h0003, 16'hffff}, r);
    `CHK(r, 16'h0001)
    $display("fill test done");
  endtask : test_fill
  // Strobe stands one cycle only: latch it while it stands
  task automatic test_pixel(input logic [25:0] d);
    logic seen;
    logic [25:0] got;
    seen = 1'b0;
    got = '0;
    fork
      u_host.pixel(d);
      for (int k = 0; k < 30 && !seen; k++)
      begin
        @(negedge core_clk_i);
        seen = (out_v === 1'b1);
        got = out_pix;
      end
    join
    `CHK(seen, 1'b1)
    `CHK(got, d)
    $display("pixel test done");
  endtask : test_pixel
  // A frame writing status returns its prior value 0; writing control off stops the inbound path
  // Return shows the value held before the frame's own write
  task automatic test_serial();
    u_host.frame({16'h0002, 16'ha5c3}, r);
    `CHK(r, 16'h0000)
    u_host.frame({16'h0002, 16'ha5c3}, r);
    `CHK(r, 16'ha5c3)
    u_host.frame({16'h0001, 16'hffff}, r);
    `CHK(r, 16'h0000)
    u_host.frame({16'h0000, 16'h0000}, r);
    `CHK(ctrl, 16'h0000)
    @(posedge core_clk_i);
    dec_valid_i <= 1'b1;
    @(posedge core_clk_i);
    dec_valid_i <= 1'b0;
    repeat (20)
    begin
      @(posedge core_clk_i);
      `CHK(in_v, 1'b0)
    end
    $display("serial test done");
  endtask : test_serial
  task automatic test_twowire();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk_i);
      twowire_data_i <= k[1];
      twowire_chip_data_i <= k[0];
      twowire_clk_i <= k[0];
      repeat (6) @(posedge core_clk_i);
      `CHK(tw_ret, k[1] & k[0])
      `CHK(tw_oe_n, k[1])
      `CHK(tw_clk_o, k[0])
      `CHK(tw_d, 1'b0)
    end
    $display("two-wire test done");
  endtask : test_twowire
  task automatic test_reset();
    @(posedge core_clk_i);
    host_reset_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    `CHK(ctrl, 16'h0001)
    host_reset_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    $display("reset test done");
  endtask : test_reset
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    test_fill();
    test_pixel(26'h2ab_cdef);
    test_pixel(26'h000_0001);
    test_serial();
    test_twowire();
    test_reset();
    test_done();
  end
endmodule : tb
`default_nettype wire
